// *** verilog/scc_pkg.sv ***
// register map and constants of the sleep and alarm clamp control block
package scc_pkg;
    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] SCC_IDX_SLEEP_ONE = 8'h18;
    localparam logic [7:0] SCC_IDX_SLEEP_TWO = 8'h19;
    localparam logic [7:0] SCC_IDX_ALARM_CLAMP = 8'h1a;
    localparam logic [7:0] SCC_IDX_ALARM_CFG = 8'h1b;
    localparam logic [7:0] SCC_IDX_AMP_ON = 8'h1c;
    localparam logic [7:0] SCC_IDX_CLAMP_CFG = 8'h1d;
    localparam int SCC_ADDR_W = 10;
    localparam int SCC_REG_W = 16;
    localparam int SCC_NTGT = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] SCC_RST_SLEEP_ONE = 16'hff00;
    localparam logic [15:0] SCC_RST_SLEEP_TWO = 16'hff00;
    localparam logic [15:0] SCC_RST_ALARM_CLAMP = 16'h0000;
    localparam logic [15:0] SCC_RST_ALARM_CFG = 16'h0000;
    localparam logic [15:0] SCC_RST_AMP_ON = 16'h0000;
    localparam logic [15:0] SCC_RST_CLAMP_CFG = 16'h0000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SCC_EN_LSB = 0;
    localparam int SCC_HOLD_LSB = 8;
    localparam int SCC_TGT_AMP = 6;
    localparam int SCC_NCONV = 6;
    localparam int SCC_POL_BIT = 14;
    localparam int SCC_AMP_ON_BIT = 0;

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] SCC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCC_RESP_SLVERR = 2'h2;
endpackage

// *** verilog/scc_hold_if.sv ***
// carrier between register logic and the per-target hold latch
`timescale 1ns/1ns
`default_nettype none
interface scc_hold_if;
    logic [6:0] sleep_in_one_req;
    logic [6:0] sleep_in_two_req;
    logic [6:0] alarm_req;
    logic [6:0] hold1;
    logic [6:0] hold2;
    logic [6:0] release_wr;
    logic [6:0] latched;
    modport ctrl (
        output sleep_in_one_req, sleep_in_two_req, alarm_req, hold1, hold2, release_wr,
        input latched
    );
    modport hold (
        input sleep_in_one_req, sleep_in_two_req, alarm_req, hold1, hold2, release_wr,
        output latched
    );
endinterface
`default_nettype wire

// *** verilog/scc_hold_latch.sv ***
// sticky clamp latch for the six converters and the amplifier output
`timescale 1ns/1ns
`default_nettype none
module scc_hold_latch (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    scc_hold_if.hold hb
);
    import scc_pkg::*;

    logic [SCC_NTGT-1:0] latched_q;
    logic [SCC_NTGT-1:0] set_d;

    // ------------------------------------------------------------
    // set terms: snoozed sleep requests and every alarm request
    // ------------------------------------------------------------
    always_comb begin
        set_d = (hb.sleep_in_one_req & hb.hold1)
              | (hb.sleep_in_two_req & hb.hold2)
              | hb.alarm_req;
    end

    // a request in the cycle of the releasing write wins
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            latched_q <= '0;
        end else begin
            latched_q <= (latched_q & ~hb.release_wr) | set_d;
        end
    end

    assign hb.latched = latched_q;
endmodule
`default_nettype wire

// *** verilog/scc_top.sv ***
// sleep and alarm clamp control with AXI4-Lite register access
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module scc_top (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_sleep_in_one,
    input wire logic i_sleep_in_two,
    input wire logic i_alarm_out_pin,
    output logic o_amp_enable_out,
    output logic [scc_pkg::SCC_NCONV-1:0] o_conv_clamp,
    input wire logic [scc_pkg::SCC_ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [scc_pkg::SCC_ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);
    import scc_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        return idx >= SCC_IDX_SLEEP_ONE && idx <= SCC_IDX_CLAMP_CFG;
    endfunction

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    logic [15:0] sleep_one_q;
    logic [15:0] sleep_two_config_q;
    logic [15:0] alarm_clamp_enable_q;
    logic [15:0] alarm_cfg_q;
    logic [15:0] amp_on_q;
    logic [15:0] clamp_cfg_q;

    logic aw_got_q;
    logic w_got_q;
    logic [7:0] aw_idx_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic [7:0] ar_idx;
    logic [15:0] rd_val;

    assign wr_fire = aw_got_q && w_got_q && !o_bvalid;
    assign ar_idx = i_araddr[SCC_ADDR_W-1:2];

    // ------------------------------------------------------------
    // write channels, taken in either order
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            aw_got_q <= 1'b0;
            aw_idx_q <= 8'h00;
            o_awready <= 1'b0;
        end else begin
            o_awready <= !aw_got_q && !o_awready && !o_bvalid;
            if (o_awready && i_awvalid) begin
                aw_got_q <= 1'b1;
                aw_idx_q <= i_awaddr[SCC_ADDR_W-1:2];
                o_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_got_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            w_got_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            o_wready <= 1'b0;
        end else begin
            o_wready <= !w_got_q && !o_wready && !o_bvalid;
            if (o_wready && i_wvalid) begin
                w_got_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
                o_wready <= 1'b0;
            end else if (wr_fire) begin
                w_got_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_bvalid <= 1'b0;
            o_bresp <= SCC_RESP_OKAY;
        end else if (wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp <= mapped(aw_idx_q) ? SCC_RESP_OKAY : SCC_RESP_SLVERR;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            sleep_one_q <= SCC_RST_SLEEP_ONE;
            sleep_two_config_q <= SCC_RST_SLEEP_TWO;
            alarm_clamp_enable_q <= SCC_RST_ALARM_CLAMP;
            alarm_cfg_q <= SCC_RST_ALARM_CFG;
            amp_on_q <= SCC_RST_AMP_ON;
            clamp_cfg_q <= SCC_RST_CLAMP_CFG;
        end else if (wr_fire) begin
            unique case (aw_idx_q)
                SCC_IDX_SLEEP_ONE: begin
                    sleep_one_q <= merge(sleep_one_q, wdata_q, wstrb_q);
                end
                SCC_IDX_SLEEP_TWO: begin
                    sleep_two_config_q <=
                        merge(sleep_two_config_q, wdata_q, wstrb_q);
                end
                SCC_IDX_ALARM_CLAMP: begin
                    alarm_clamp_enable_q <=
                        merge(alarm_clamp_enable_q, wdata_q, wstrb_q);
                end
                SCC_IDX_ALARM_CFG: begin
                    alarm_cfg_q <= merge(alarm_cfg_q, wdata_q, wstrb_q);
                end
                SCC_IDX_AMP_ON: begin
                    amp_on_q <= merge(amp_on_q, wdata_q, wstrb_q);
                end
                SCC_IDX_CLAMP_CFG: begin
                    clamp_cfg_q <= merge(clamp_cfg_q, wdata_q, wstrb_q);
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    always_comb begin
        unique case (ar_idx)
            SCC_IDX_SLEEP_ONE: rd_val = sleep_one_q;
            SCC_IDX_SLEEP_TWO: rd_val = sleep_two_config_q;
            SCC_IDX_ALARM_CLAMP: rd_val = alarm_clamp_enable_q;
            SCC_IDX_ALARM_CFG: rd_val = alarm_cfg_q;
            SCC_IDX_AMP_ON: rd_val = amp_on_q;
            SCC_IDX_CLAMP_CFG: rd_val = clamp_cfg_q;
            default: rd_val = 16'h0000;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= SCC_RESP_OKAY;
        end else begin
            o_arready <= !o_arready && !o_rvalid;
            if (o_arready && i_arvalid) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= {16'h0000, rd_val};
                o_rresp <= mapped(ar_idx) ? SCC_RESP_OKAY : SCC_RESP_SLVERR;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // clamp requests per target
    // ------------------------------------------------------------
    scc_hold_if hb ();
    logic alarm_active;
    logic [SCC_NTGT-1:0] forced;
    logic [SCC_NTGT-1:0] wr_amp_mask;
    logic [SCC_NTGT-1:0] wr_clamp_mask;

    // polarity 0 means the pin is active low
    assign alarm_active = alarm_cfg_q[SCC_POL_BIT] ? i_alarm_out_pin
        : !i_alarm_out_pin;

    assign hb.sleep_in_one_req = {SCC_NTGT{i_sleep_in_one}}
                         & sleep_one_q[SCC_EN_LSB +: SCC_NTGT];
    assign hb.sleep_in_two_req = sleep_two_config_q[SCC_EN_LSB +: SCC_NTGT]
        & {SCC_NTGT{i_sleep_in_two}};
    assign hb.alarm_req = alarm_clamp_enable_q[SCC_EN_LSB +: SCC_NTGT]
        & {SCC_NTGT{alarm_active}};
    assign hb.hold1 = sleep_one_q[SCC_HOLD_LSB +: SCC_NTGT];
    assign hb.hold2 =
        sleep_two_config_q[SCC_HOLD_LSB +: SCC_NTGT];

    // amplifier released by its own register, converters by clamp config
    assign wr_amp_mask = (wr_fire && aw_idx_q == SCC_IDX_AMP_ON)
                       ? 7'h40 : 7'h00;
    assign wr_clamp_mask = (wr_fire && aw_idx_q == SCC_IDX_CLAMP_CFG)
                         ? 7'h3f : 7'h00;
    assign hb.release_wr = wr_amp_mask | wr_clamp_mask;

    scc_hold_latch u_hold (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .hb(hb)
    );

    assign forced = hb.sleep_in_one_req | hb.sleep_in_two_req | hb.alarm_req
                  | hb.latched;

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_amp_enable_out <= 1'b0;
            o_conv_clamp <= '0;
        end else begin
            o_amp_enable_out <= amp_on_q[SCC_AMP_ON_BIT]
                              && !forced[SCC_TGT_AMP];
            o_conv_clamp <= clamp_cfg_q[SCC_NCONV-1:0]
                          | forced[SCC_NCONV-1:0];
        end
    end
endmodule
`default_nettype wire

// *** verification/scc_properties.sv ***
// bus and reset checks on the clamp control ports
`timescale 1ns/1ns
`default_nettype none
module scc_properties (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic o_amp_enable_out,
    input wire logic [scc_pkg::SCC_NCONV-1:0] o_conv_clamp,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic o_rvalid,
    input wire logic i_rready
);
    import scc_pkg::*;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking dcb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    sequence wr_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence rd_taken;
        i_arvalid && o_arready;
    endsequence
    rst_quiet_a: assert property (disable iff (1'b0) i_sys_rst |=>
        !o_amp_enable_out && o_conv_clamp == '0 && !o_bvalid && !o_rvalid)
        else $error("outputs not quiet in reset");
    bresp_hold_a: assert property (o_bvalid && !i_bready |=>
        o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
    rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid &&
        $stable(o_rdata) && $stable(o_rresp)) else $error("read answer moved");
    aw_busy_a: assert property (o_bvalid |-> !o_awready)
        else $error("address taken during answer");
    w_busy_a: assert property (o_bvalid |-> !o_wready)
        else $error("data taken during answer");
    ar_busy_a: assert property (o_rvalid |-> !o_arready)
        else $error("read taken during answer");
    rd_answer_a: assert property (rd_taken |-> ##[1:2] o_rvalid)
        else $error("read answer late");
    wr_answer_a: assert property (wr_taken |-> ##[1:2] o_bvalid)
        else $error("write answer late");
endmodule
bind scc_top scc_properties u_scc_properties (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .o_amp_enable_out(o_amp_enable_out),
    .o_conv_clamp(o_conv_clamp), .i_awvalid(i_awvalid),
    .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready));
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the clamp control block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import scc_pkg::*;
    logic clk = 0, rst = 1, s1 = 0, s2 = 0, al = 1;
    logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [9:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'h3;
    logic [1:0] bresp, rresp;
    logic awr, wr_rdy, bv, arr, rv, amp;
    logic [5:0] clamp;
    int n_mismatch = 0, n_tests = 0;
    always #5 clk = ~clk;
    scc_top u_scc_top (.i_ref_clk(clk), .i_sys_rst(rst),
        .i_sleep_in_one(s1), .i_sleep_in_two(s2), .i_alarm_out_pin(al),
        .o_amp_enable_out(amp), .o_conv_clamp(clamp), .i_awaddr(awaddr),
        .i_awvalid(awv), .o_awready(awr), .i_wdata(wdata), .i_wstrb(wstrb),
        .i_wvalid(wv), .o_wready(wr_rdy), .o_bresp(bresp), .o_bvalid(bv),
        .i_bready(bready), .i_araddr(araddr), .i_arvalid(arv),
        .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv),
        .i_rready(rready));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic late;
        n_mismatch++;
        stop_test;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic see(input logic a, input logic [5:0] c);
        tick(3);
        @(negedge clk);
        chk({9'h0, amp, clamp}, {9'h0, a, c});
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [15:0] d,
                      input logic [1:0] er = SCC_RESP_OKAY);
        logic a, w;
        int k;
        a = 0;
        w = 0;
        awaddr <= {idx, 2'h0};
        wdata <= {16'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        for (k = 0; k < 40 && !(a && w); k++) begin
            @(posedge clk);
            if (!a && awr) begin
                a = 1;
                awv <= 1'b0;
            end
            if (!w && wr_rdy) begin
                w = 1;
                wv <= 1'b0;
            end
        end
        if (!(a && w)) late();
        for (k = 0; k < 40 && !bv; k++) @(posedge clk);
        if (!bv) late();
        chk({14'h0, bresp}, {14'h0, er});
        bready <= 1'b1;
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [15:0] exp,
                      input logic [1:0] er);
        int k;
        araddr <= {idx, 2'h0};
        arv <= 1'b1;
        for (k = 0; k < 40 && !(arv && arr); k++) @(posedge clk);
        if (!arr) late();
        arv <= 1'b0;
        for (k = 0; k < 40 && !rv; k++) @(posedge clk);
        if (!rv) late();
        rready <= 1'b1;
        @(posedge clk);
        rready <= 1'b0;
        chk(rdata[15:0], exp);
        chk({14'h0, rresp}, {14'h0, er});
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        tick(5);
        rst <= 1'b0;
        tick(2);
        rd(SCC_IDX_SLEEP_TWO, 16'hff00, SCC_RESP_OKAY);
        rd(SCC_IDX_ALARM_CLAMP, 16'h0000, SCC_RESP_OKAY);
        wr(8'h00, 16'h1234, SCC_RESP_SLVERR);
        rd(8'h00, 16'h0000, SCC_RESP_SLVERR);
        wr(SCC_IDX_ALARM_CLAMP, 16'hff80);
        rd(SCC_IDX_ALARM_CLAMP, 16'hff80, SCC_RESP_OKAY);
        wstrb <= 4'h1;
        wr(SCC_IDX_ALARM_CFG, 16'h40aa);
        rd(SCC_IDX_ALARM_CFG, 16'h00aa, SCC_RESP_OKAY);
        wstrb <= 4'h3;
        wr(SCC_IDX_AMP_ON, 16'h0001);
        see(1'b1, 6'h00);
        al <= 1'b0;
        see(1'b1, 6'h00);
        al <= 1'b1;
        s2 <= 1'b1;
        see(1'b1, 6'h00);
        s2 <= 1'b0;
        wr(SCC_IDX_SLEEP_TWO, 16'h4040);
        s2 <= 1'b1;
        see(1'b0, 6'h00);
        s2 <= 1'b0;
        see(1'b0, 6'h00);
        wr(SCC_IDX_AMP_ON, 16'h0001);
        see(1'b1, 6'h00);
        wr(SCC_IDX_SLEEP_TWO, 16'h0040);
        s2 <= 1'b1;
        see(1'b0, 6'h00);
        s2 <= 1'b0;
        see(1'b1, 6'h00);
        wr(SCC_IDX_SLEEP_TWO, 16'h0a1b);
        s2 <= 1'b1;
        see(1'b1, 6'h1b);
        s2 <= 1'b0;
        see(1'b1, 6'h0a);
        wr(SCC_IDX_CLAMP_CFG, 16'h0000);
        see(1'b1, 6'h00);
        wr(SCC_IDX_SLEEP_TWO, 16'hff00);
        wr(SCC_IDX_ALARM_CLAMP, 16'h0045);
        al <= 1'b0;
        see(1'b0, 6'h05);
        al <= 1'b1;
        see(1'b0, 6'h05);
        wr(SCC_IDX_AMP_ON, 16'h0001);
        wr(SCC_IDX_CLAMP_CFG, 16'h0000);
        see(1'b1, 6'h00);
        wr(SCC_IDX_ALARM_CFG, 16'h4000);
        see(1'b0, 6'h05);
        al <= 1'b0;
        wr(SCC_IDX_ALARM_CLAMP, 16'h0000);
        wr(SCC_IDX_AMP_ON, 16'h0001);
        wr(SCC_IDX_CLAMP_CFG, 16'h0000);
        see(1'b1, 6'h00);
        wr(SCC_IDX_SLEEP_ONE, 16'h0001);
        wr(SCC_IDX_SLEEP_TWO, 16'h0001);
        s1 <= 1'b1;
        s2 <= 1'b1;
        see(1'b1, 6'h01);
        s2 <= 1'b0;
        see(1'b1, 6'h01);
        s1 <= 1'b0;
        see(1'b1, 6'h00);
        stop_test();
    end
endmodule
`default_nettype wire
